//--- handler_state_pkg.sv
package handler_state_pkg;

  localparam logic [11:0] system_handler_state_offset = 12'hd24;
  localparam logic [31:0] system_handler_state_reset  = 32'h0000_0000;

  // flag indices of the exception side vectors
  localparam int unsigned flag_count       = 6;
  localparam int unsigned idx_memory_fault = 0;
  localparam int unsigned idx_bus_fault    = 1;
  localparam int unsigned idx_usage_fault  = 2;
  localparam int unsigned idx_supervisor   = 3;
  localparam int unsigned idx_debug_mon    = 4;
  localparam int unsigned idx_pendable     = 5;

  // bit positions in the register word
  localparam int unsigned pos_memory_fault = 0;
  localparam int unsigned pos_bus_fault    = 1;
  localparam int unsigned pos_usage_fault  = 3;
  localparam int unsigned pos_supervisor   = 7;
  localparam int unsigned pos_debug_mon    = 8;
  localparam int unsigned pos_pendable     = 10;

  // writable bits; all others read zero
  localparam logic [31:0] active_mask = 32'h0000_058b;

  localparam logic [1:0] htrans_idle   = 2'h0;
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [2:0] hsize_word    = 3'h2;

endpackage : handler_state_pkg

//--- active_flag_bank.sv
`timescale 1ns/1ps
module active_flag_bank
(
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic [5:0]  enter_i,
  input  wire logic [5:0]  leave_i,
  input  wire logic        wr_en_i,
  input  wire logic [5:0]  wr_data_i,
  output logic      [5:0]  flags_o
);

  logic [5:0] flags_reg;
  logic [5:0] flags_next;

  ////////////////////////////////////////////////////////////////////////////
  // write first, then exception events override it
  always_comb
  begin
    flags_next = flags_reg;
    if (wr_en_i)
    begin
      flags_next = wr_data_i;
    end
    flags_next = (flags_next & ~leave_i) | enter_i;
  end

  // synchronous reset to all clear
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      flags_reg <= '0;
    end
    else
    begin
      flags_reg <= flags_next;
    end
  end

  assign flags_o = flags_reg;

endmodule : active_flag_bank

//--- system_handler_active_status.sv
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module system_handler_active_status
(
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic [5:0]  handler_enter_i,
  input  wire logic [5:0]  handler_return_i,
  output logic      [5:0]  active_flags_o
);

  // data phase tracker states
  typedef enum logic [1:0]
  {
    phase_idle  = 2'b00,
    phase_write = 2'b01,
    phase_read  = 2'b10
  } data_phase_t;

  data_phase_t phase_reg;
  data_phase_t phase_next;
  logic        wr_pending;   // write data phase under way
  logic        rd_pending;   // read data phase under way
  logic [31:0] hrdata_reg;
  logic        hreadyout_reg;
  logic        hresp_reg;
  logic [5:0]  active_reg;
  logic [5:0]  bank_flags;
  logic [5:0]  wr_flags;
  logic        addr_hit;
  logic        phase_ok;
  logic        wr_take;
  logic        rd_take;

  ////////////////////////////////////////////////////////////////////////////
  // bit position in the register word of one flag of the exception side vector
  function automatic int unsigned flag_pos(input int unsigned idx);
    int unsigned p;
    p = handler_state_pkg::pos_memory_fault;
    unique case (idx)
      handler_state_pkg::idx_memory_fault: p = handler_state_pkg::pos_memory_fault;
      handler_state_pkg::idx_bus_fault:    p = handler_state_pkg::pos_bus_fault;
      handler_state_pkg::idx_usage_fault:  p = handler_state_pkg::pos_usage_fault;
      handler_state_pkg::idx_supervisor:   p = handler_state_pkg::pos_supervisor;
      handler_state_pkg::idx_debug_mon:    p = handler_state_pkg::pos_debug_mon;
      handler_state_pkg::idx_pendable:     p = handler_state_pkg::pos_pendable;
      default:                             p = handler_state_pkg::pos_memory_fault;
    endcase
    return p;
  endfunction : flag_pos

  // pack flag vector into the register word, reserved bits zero
  function automatic logic [31:0] pack_word(input logic [5:0] f);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int unsigned i = 0; i < handler_state_pkg::flag_count; i++)
    begin
      w[flag_pos(i)] = f[i];
    end
    return w & handler_state_pkg::active_mask;
  endfunction : pack_word

  // pick the writable bits out of a written word; other bits dropped
  function automatic logic [5:0] unpack_word(input logic [31:0] w);
    logic [5:0] f;
    f = 6'h00;
    for (int unsigned i = 0; i < handler_state_pkg::flag_count; i++)
    begin
      f[i] = w[flag_pos(i)];
    end
    return f;
  endfunction : unpack_word

  // a transfer is taken when selected, ready and nonsequential
  function automatic logic xfer_taken(input logic sel, input logic rdy, input logic [1:0] trans);
    return sel && rdy && (trans == handler_state_pkg::htrans_nonseq);
  endfunction : xfer_taken

  // only the low twelve address bits are decoded
  function automatic logic reg_hit(input logic [31:0] addr);
    return addr[11:0] == handler_state_pkg::system_handler_state_offset;
  endfunction : reg_hit

  ////////////////////////////////////////////////////////////////////////////
  // address phase decode
  assign addr_hit = reg_hit(haddr_i);
  assign phase_ok = xfer_taken(hsel_i, hready_i, htrans_i);
  assign wr_take  = phase_ok && hwrite_i && addr_hit;
  assign rd_take  = phase_ok && !hwrite_i && addr_hit;

  // write data arrive one cycle after their address, in the data phase
  assign wr_flags = unpack_word(hwdata_i);

  // next data phase from the address phase taken at this edge
  always_comb
  begin
    phase_next = phase_idle;
    if (wr_take)
    begin
      phase_next = phase_write;
    end
    else if (rd_take)
    begin
      phase_next = phase_read;
    end
  end

  // data phase state; back to back transfers simply reload it
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      phase_reg <= phase_idle;
    end
    else
    begin
      phase_reg <= phase_next;
    end
  end

  // data phase kind; the spare code behaves as idle
  always_comb
  begin
    wr_pending = 1'b0;
    rd_pending = 1'b0;
    unique case (phase_reg)
      phase_idle:  wr_pending = 1'b0;
      phase_write: wr_pending = 1'b1;
      phase_read:  rd_pending = 1'b1;
      default:     wr_pending = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // active flag storage
  active_flag_bank u_flags
  (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .enter_i   (handler_enter_i),
    .leave_i   (handler_return_i),
    .wr_en_i   (wr_pending),
    .wr_data_i (wr_flags),
    .flags_o   (bank_flags)
  );

  // read data registered at the address phase, cleared when its data phase ends
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      hrdata_reg <= handler_state_pkg::system_handler_state_reset;
    end
    else if (rd_take)
    begin
      hrdata_reg <= pack_word(bank_flags);
    end
    else if (rd_pending)
    begin
      hrdata_reg <= 32'h0000_0000;
    end
  end

  // flag copy for the exception logic
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      active_reg <= 6'h00;
    end
    else
    begin
      active_reg <= bank_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // no wait states: ready leaves reset high and stays there
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      hreadyout_reg <= 1'b1;
    end
    else
    begin
      hreadyout_reg <= 1'b1;
    end
  end

  // every transfer answers okay
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      hresp_reg <= 1'b0;
    end
    else
    begin
      hresp_reg <= 1'b0;
    end
  end

  // outputs straight from their registers
  assign hrdata_o       = hrdata_reg;
  assign hreadyout_o    = hreadyout_reg;
  assign hresp_o        = hresp_reg;
  assign active_flags_o = active_reg;

endmodule : system_handler_active_status

//--- handler_state_props.sv
`timescale 1ns/1ps
module handler_state_props
(
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_o,
  input  wire logic        hreadyout_o,
  input  wire logic        hresp_o,
  input  wire logic [5:0]  handler_enter_i,
  input  wire logic [5:0]  handler_return_i,
  input  wire logic [5:0]  active_flags_o
);
  // transfer to the register taken at this edge
  wire       hit  = hsel_i & hready_i & (htrans_i == 2'h2) & (haddr_i[11:0] == 12'hd24);
  wire       rd   = hit & !hwrite_i;
  wire [5:0] wmap = {hwdata_i[10], hwdata_i[8], hwdata_i[7], hwdata_i[3], hwdata_i[1], hwdata_i[0]};
  wire [5:0] clr  = handler_return_i & ~handler_enter_i;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // write whose data phase sees no exception event
  sequence s_quiet_wr;
    hit & hwrite_i ##1 (handler_enter_i == 6'h0 && handler_return_i == 6'h0);
  endsequence
  a_read_map : assert property (rd |=> hrdata_o[10:0] == {active_flags_o[5], 1'b0, active_flags_o[4:3],
    3'h0, active_flags_o[2], 1'b0, active_flags_o[1:0]}) else $error("read word does not match flags");
  a_reserved_zero : assert property (rd |=> (hrdata_o & 32'hffff_fa74) == 32'h0) else $error("reserved bit set");
  a_read_idle : assert property (!rd |=> hrdata_o == 32'h0) else $error("read data outside read");
  a_write_flags : assert property (s_quiet_wr |-> ##2 active_flags_o == $past(wmap, 2)) else $error("write lost");
  a_enter_sets : assert property (handler_enter_i != 6'h0 |-> ##2
    (active_flags_o & $past(handler_enter_i, 2)) == $past(handler_enter_i, 2)) else $error("entry not set");
  a_return_clears : assert property (clr != 6'h0 |-> ##2 (active_flags_o & $past(clr, 2)) == 6'h0)
    else $error("return not cleared");
  a_reset_clear : assert property (disable iff (1'b0) (!reset_n_i) [*2] |=> active_flags_o == 6'h0 && hrdata_o == 32'h0)
    else $error("reset left state");
  a_ready_okay : assert property (hreadyout_o && !hresp_o) else $error("wait or error response");
endmodule : handler_state_props
bind system_handler_active_status handler_state_props i_props (.*);

//--- tb.sv
`timescale 1ns/1ps
module tb;
  logic        clk_sys_i = 0;
  logic        reset_n_i = 0;
  logic        hsel_i = 0;
  logic        hwrite_i = 0;
  logic [1:0]  htrans_i = 0;
  logic [31:0] haddr_i = 0;
  logic [31:0] hwdata_i = 0;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        hresp_o;
  logic [5:0]  handler_enter_i = 0;
  logic [5:0]  handler_return_i = 0;
  logic [5:0]  active_flags_o;
  logic [31:0] r;
  logic [31:0] d;
  int          fail_count = 0;
  int          check_count = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  system_handler_active_status i_system_handler_active_status (.clk_sys_i, .reset_n_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hsize_i(handler_state_pkg::hsize_word), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
    .hresp_o, .handler_enter_i, .handler_return_i, .active_flags_o);
  ////////////////////////////////////////////////////////////////
  // expected register word from a flag vector
  function automatic logic [31:0] to_word(logic [5:0] f);
    return {21'h0, f[5], 1'b0, f[4:3], 3'h0, f[2], 1'b0, f[1:0]};
  endfunction : to_word
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  // one single word transfer, read data left in r
  task automatic xfer(logic w, logic [31:0] a, logic [31:0] dd);
    hsel_i   <= 1'b1;
    haddr_i  <= a;
    hwrite_i <= w;
    htrans_i <= handler_state_pkg::htrans_nonseq;
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    htrans_i <= handler_state_pkg::htrans_idle;
    hwdata_i <= dd;
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    r = hrdata_o;
  endtask : xfer
  // exception entry and return events for one cycle
  task automatic pulse(logic [5:0] e, logic [5:0] c);
    handler_enter_i  <= e;
    handler_return_i <= c;
    @(posedge clk_sys_i);
    handler_enter_i  <= 6'h0;
    handler_return_i <= 6'h0;
  endtask : pulse
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////
  // watchdog
  initial
  begin
    repeat (3000) @(posedge clk_sys_i);
    fail_count++;
    report_and_stop();
  end
  // main sequence
  initial
  begin
    void'($urandom(15));
    repeat (10) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    xfer(1'b0, 32'hd24, 32'h0);
    chk(r, 32'h0);
    for (int i = 0; i < 24; i++)
    begin
      d = (i < 11) ? (32'h1 << i) : $urandom;
      xfer(1'b1, 32'hd24, d);
      xfer(1'b0, 32'hd24, 32'h0);
      chk(r, d & handler_state_pkg::active_mask);
    end
    // read-modify-write that sets bit 7 and keeps every other bit as read
    xfer(1'b0, 32'hd24, 32'h0);
    d = r | 32'h0000_0080;
    xfer(1'b1, 32'hd24, d);
    xfer(1'b0, 32'hd24, 32'h0);
    chk(r, d);
    $display("test register bits done");
    xfer(1'b1, 32'hd28, 32'hffff_ffff);
    xfer(1'b0, 32'hd28, 32'h0);
    chk(r, 32'h0);
    pulse(6'h3f, 6'h0);
    xfer(1'b0, 32'hd24, 32'h0);
    chk(r, to_word(6'h3f));
    pulse(6'h01, 6'h3f);
    xfer(1'b0, 32'hd24, 32'h0);
    chk(r, to_word(6'h01));
    // exception events in the data phase of a write beat the written value
    fork
      xfer(1'b1, 32'hd24, 32'h0);
      begin
        @(posedge clk_sys_i);
        pulse(6'h05, 6'h00);
      end
    join
    xfer(1'b0, 32'hd24, 32'h0);
    chk(r, to_word(6'h05));
    fork
      xfer(1'b1, 32'hd24, 32'h0000_058b);
      begin
        @(posedge clk_sys_i);
        pulse(6'h00, 6'h1c);
      end
    join
    xfer(1'b0, 32'hd24, 32'h0);
    chk(r, to_word(6'h23));
    chk({26'h0, active_flags_o}, 32'h0000_0023);
    $display("test exception events done");
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    xfer(1'b0, 32'hd24, 32'h0);
    chk(r, 32'h0);
    $display("test mid reset done");
    report_and_stop();
  end
endmodule : tb
